/* design/psr_consts.vh */
// constants for the pseudo-static ddr memory write path
// assumes inclusion by bare name from the write path design file, the checker and the top bench; the fifo and the host model do not include it
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

// ============================================================
// command-address word layout (48 bits, three bus clocks)
`define PSR_CA_EDGES        8'd6
`define PSR_CA_RW_BIT       47
`define PSR_CA_SPACE_BIT    46
`define PSR_CA_BURST_BIT    45
`define PSR_CA_ROW_MSB      35
`define PSR_CA_ROW_LSB      22
`define PSR_CA_UCOL_MSB     21
`define PSR_CA_UCOL_LSB     16
`define PSR_CA_LCOL_MSB     2
`define PSR_CA_LCOL_LSB     0
`define PSR_CA_RSEL_MSB     31
`define PSR_CA_RSEL_LSB     24
`define PSR_CA_RIDX_MSB     7
`define PSR_CA_RIDX_LSB     0

// ============================================================
// register space selection
`define PSR_RSEL_CONFIG     8'h01
`define PSR_RIDX_PRIMARY    8'h00
`define PSR_RIDX_SECONDARY  8'h01

// ============================================================
// register reset values; identification contents are arbitrary
`define PSR_PRIMARY_RST     16'h8F1F
`define PSR_SECONDARY_RST   16'h0001
`define PSR_IDENT0_VAL      16'h0D80
`define PSR_IDENT1_VAL      16'h0000

// ============================================================
// primary_config fields
`define PSR_LAT_MSB         7
`define PSR_LAT_LSB         4
`define PSR_FIXED_BIT       3
`define PSR_LEGACY_BIT      2
`define PSR_BLEN_MSB        1
`define PSR_BLEN_LSB        0

// ============================================================
// initial latency codes and clock counts
`define PSR_LAT_CODE_5      4'h0
`define PSR_LAT_CODE_6      4'h1
`define PSR_LAT_CODE_3      4'hE
`define PSR_LAT_CODE_4      4'hF
`define PSR_LAT_CLK_3       4'h3
`define PSR_LAT_CLK_4       4'h4
`define PSR_LAT_CLK_5       4'h5
`define PSR_LAT_CLK_6       4'h6

// ============================================================
// wrapped burst lengths in words
`define PSR_BLEN_CODE_128B  2'h0
`define PSR_BLEN_CODE_64B   2'h1
`define PSR_BLEN_CODE_16B   2'h2
`define PSR_BLEN_WORDS_128B 7'h40
`define PSR_BLEN_WORDS_64B  7'h20
`define PSR_BLEN_WORDS_16B  7'h08
`define PSR_BLEN_WORDS_32B  7'h10

`endif

/* design/psr_wr_fifo.v */
// word fifo between the bus capture logic and the memory array port
// assumes one clock; both sides use a valid/ready handshake
`timescale 1ns/1ps

module psr_wr_fifo #(
    parameter WIDTH = 41,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // filling side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;

    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    // ========================================================
    // pointers carry one extra bit so full and empty differ
    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                         (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign push        = in_valid_i & ~full;
    assign pop         = out_ready_i & ~empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule

/* design/psr_write_path.v */
// write path and address map of a pseudo-static ddr memory slave
// assumes the bus clock runs well below a quarter of clk_i, since
// every pin is oversampled through two flip-flops
`timescale 1ns/1ps
`include "psr_consts.vh"

module psr_write_path #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // memory bus pins
    input  wire        cs_n_i,
    input  wire        bus_clk_i,
    input  wire [7:0]  dq_i,
    input  wire        strobe_mask_i,
    output wire        strobe_mask_o,
    output wire        strobe_mask_oe_o,
    // refresh indication from the array controller
    input  wire        refresh_due_i,
    // memory array write port
    output wire        mem_wr_valid_o,
    input  wire        mem_wr_ready_i,
    output wire [22:0] mem_wr_addr_o,
    output wire [15:0] mem_wr_data_o,
    output wire [1:0]  mem_wr_be_o,
    // status and register contents
    output wire        wr_fifo_ready_o,
    output reg         overflow_o,
    output reg         busy_o,
    output wire [15:0] device_ident_word0_o,
    output wire [15:0] device_ident_word1_o,
    output reg  [15:0] primary_config_o,
    output reg  [15:0] secondary_config_o
);

    // ========================================================
    // states
    localparam ST_IDLE = 5'b00001;
    localparam ST_CA   = 5'b00010;
    localparam ST_LAT  = 5'b00100;
    localparam ST_DATA = 5'b01000;
    localparam ST_SKIP = 5'b10000;

    // ========================================================
    // functions
    function [3:0] lat_clocks;
        input [3:0] code;
        begin
            case (code)
                `PSR_LAT_CODE_5: lat_clocks = `PSR_LAT_CLK_5;
                `PSR_LAT_CODE_6: lat_clocks = `PSR_LAT_CLK_6;
                `PSR_LAT_CODE_3: lat_clocks = `PSR_LAT_CLK_3;
                `PSR_LAT_CODE_4: lat_clocks = `PSR_LAT_CLK_4;
                // reserved codes fall back to the default latency
                default:         lat_clocks = `PSR_LAT_CLK_6;
            endcase
        end
    endfunction

    function [6:0] blen_words;
        input [1:0] code;
        begin
            case (code)
                `PSR_BLEN_CODE_128B: blen_words = `PSR_BLEN_WORDS_128B;
                `PSR_BLEN_CODE_64B:  blen_words = `PSR_BLEN_WORDS_64B;
                `PSR_BLEN_CODE_16B:  blen_words = `PSR_BLEN_WORDS_16B;
                default:             blen_words = `PSR_BLEN_WORDS_32B;
            endcase
        end
    endfunction

    // wrapped advance stays inside the aligned group
    function [22:0] wrap_next;
        input [22:0] addr;
        input [22:0] mask;
        reg   [22:0] inc;
        begin
            inc       = addr + 23'h000001;
            wrap_next = (addr & ~mask) | (inc & mask);
        end
    endfunction

    // ========================================================
    // pin synchronisers
    reg        cs_s1;
    reg        cs_s2;
    reg        ck_s1;
    reg        ck_s2;
    reg        ck_d;
    reg [7:0]  dq_s1;
    reg [7:0]  dq_s2;
    reg        sm_s1;
    reg        sm_s2;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_d  <= 1'b0;
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            sm_s1 <= 1'b0;
            sm_s2 <= 1'b0;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            ck_s1 <= bus_clk_i;
            ck_s2 <= ck_s1;
            ck_d  <= ck_s2;
            dq_s1 <= dq_i;
            dq_s2 <= dq_s1;
            sm_s1 <= strobe_mask_i;
            sm_s2 <= sm_s1;
        end
    end

    // edges are seen only while the master toggles the clock
    wire ck_rise = ck_s2 & ~ck_d;
    wire ck_fall = ~ck_s2 & ck_d;
    wire ck_edge = ck_rise | ck_fall;

    // ========================================================
    // transaction state
    reg [4:0]  state;
    reg [7:0]  edge_cnt;
    reg [47:0] ca_word;
    reg        add_lat;
    reg        strobe_drive;
    reg        reg_space;
    reg        linear;
    reg        legacy;
    reg [22:0] wrap_mask;
    reg [22:0] grp_base;
    reg [6:0]  wrap_left;
    reg [22:0] cur_addr;
    reg [7:0]  byte_a;
    reg        mask_a;
    reg        push_valid;
    reg [40:0] push_data;

    wire [47:0] ca_full = {ca_word[39:0], dq_s2};
    wire        fifo_in_ready;
    wire [40:0] fifo_out;
    wire [6:0]  blen = blen_words(primary_config_o[`PSR_BLEN_MSB:
                                                   `PSR_BLEN_LSB]);
    wire [3:0]  lat = lat_clocks(primary_config_o[`PSR_LAT_MSB:
                                                  `PSR_LAT_LSB]);
    // latency in bus clock edges, doubled when extra latency shows
    wire [7:0]  lat_edges = add_lat ? {2'b00, lat, 2'b00} :
                                      {3'b000, lat, 1'b0};

    // word address: row, upper column, word in half-page
    wire [22:0] ca_addr = {ca_full[`PSR_CA_ROW_MSB:`PSR_CA_ROW_LSB],
                           ca_full[`PSR_CA_UCOL_MSB:`PSR_CA_UCOL_LSB],
                           ca_full[`PSR_CA_LCOL_MSB:`PSR_CA_LCOL_LSB]};
    wire [22:0] blen_mask = {16'h0000, blen - 7'h01};

    assign strobe_mask_o    = strobe_drive;
    assign strobe_mask_oe_o = (state == ST_CA);
    assign wr_fifo_ready_o  = fifo_in_ready;
    assign device_ident_word0_o = `PSR_IDENT0_VAL;
    assign device_ident_word1_o = `PSR_IDENT1_VAL;
    assign mem_wr_addr_o    = fifo_out[40:18];
    assign mem_wr_data_o    = fifo_out[17:2];
    assign mem_wr_be_o      = fifo_out[1:0];

    // ========================================================
    // main sequencer
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state              <= ST_IDLE;
            edge_cnt           <= 8'h00;
            ca_word            <= 48'h000000000000;
            add_lat            <= 1'b0;
            strobe_drive       <= 1'b0;
            reg_space          <= 1'b0;
            linear             <= 1'b0;
            legacy             <= 1'b0;
            wrap_mask          <= 23'h000000;
            grp_base           <= 23'h000000;
            wrap_left          <= 7'h00;
            cur_addr           <= 23'h000000;
            byte_a             <= 8'h00;
            mask_a             <= 1'b0;
            push_valid         <= 1'b0;
            push_data          <= 41'h00000000000;
            overflow_o         <= 1'b0;
            busy_o             <= 1'b0;
            primary_config_o   <= `PSR_PRIMARY_RST;
            secondary_config_o <= `PSR_SECONDARY_RST;
        end else begin
            push_valid <= 1'b0;
            if (push_valid && !fifo_in_ready) begin
                // data phase cannot stall, so a full fifo loses the word
                overflow_o <= 1'b1;
            end
            if (cs_s2) begin
                // chip select high ends any transaction at once
                state        <= ST_IDLE;
                busy_o       <= 1'b0;
                strobe_drive <= 1'b0;
            end else begin
                case (state)
                ST_IDLE: begin
                    busy_o   <= 1'b1;
                    edge_cnt <= 8'h00;
                    // a start with the clock high is not a legal opening
                    if (ck_s2) begin
                        state <= ST_SKIP;
                    end else begin
                        state <= ST_CA;
                        // latency need shown before the command is known
                        add_lat <= primary_config_o[`PSR_FIXED_BIT] |
                                   refresh_due_i;
                        strobe_drive <= primary_config_o[`PSR_FIXED_BIT] |
                                        refresh_due_i;
                        // a word lost in this very cycle still counts
                        overflow_o <= push_valid & ~fifo_in_ready;
                    end
                end
                ST_CA: begin
                    if (ck_edge) begin
                        ca_word  <= ca_full;
                        edge_cnt <= edge_cnt + 8'h01;
                        if (edge_cnt == `PSR_CA_EDGES - 8'h01) begin
                            edge_cnt  <= 8'h00;
                            reg_space <= ca_full[`PSR_CA_SPACE_BIT];
                            linear    <= ca_full[`PSR_CA_BURST_BIT];
                            legacy    <= primary_config_o[`PSR_LEGACY_BIT];
                            wrap_mask <= blen_mask;
                            grp_base  <= ca_addr & ~blen_mask;
                            wrap_left <= blen;
                            cur_addr  <= ca_addr;
                            if (ca_full[`PSR_CA_RW_BIT]) begin
                                // reads are served elsewhere
                                state <= ST_SKIP;
                            end else if (ca_full[`PSR_CA_SPACE_BIT]) begin
                                state <= ST_DATA;
                            end else begin
                                state <= ST_LAT;
                            end
                        end
                    end
                end
                ST_LAT: begin
                    // the master's strobe preamble is not checked here
                    if (ck_edge) begin
                        edge_cnt <= edge_cnt + 8'h01;
                        if (edge_cnt == lat_edges - 8'h01) begin
                            edge_cnt <= 8'h00;
                            state    <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (ck_rise) begin
                        byte_a <= dq_s2;
                        mask_a <= sm_s2;
                    end
                    if (ck_fall) begin
                        if (reg_space) begin
                            // single word register writes, big-endian
                            state <= ST_SKIP;
                            if (ca_word[`PSR_CA_RSEL_MSB:`PSR_CA_RSEL_LSB]
                                    == `PSR_RSEL_CONFIG) begin
                                if (ca_word[`PSR_CA_RIDX_MSB:
                                            `PSR_CA_RIDX_LSB]
                                        == `PSR_RIDX_PRIMARY) begin
                                    // strobe plays no part here
                                    primary_config_o <= {byte_a, dq_s2};
                                end else if (ca_word[`PSR_CA_RIDX_MSB:
                                                     `PSR_CA_RIDX_LSB]
                                        == `PSR_RIDX_SECONDARY) begin
                                    secondary_config_o <= {byte_a, dq_s2};
                                end
                            end
                        end else begin
                            push_valid <= 1'b1;
                            // strobe high masks the byte
                            push_data  <= {cur_addr, byte_a, dq_s2,
                                           ~mask_a, ~sm_s2};
                            if (linear) begin
                                // natural rollover past the last word
                                cur_addr <= cur_addr + 23'h000001;
                            end else if (!legacy && wrap_left == 7'h01) begin
                                // hybrid: one wrap, then linear
                                cur_addr <= grp_base +
                                            {16'h0000, blen_mask[6:0]} +
                                            23'h000001;
                                linear   <= 1'b1;
                            end else begin
                                cur_addr <= wrap_next(cur_addr,
                                                      wrap_mask);
                            end
                            wrap_left <= wrap_left - 7'h01;
                        end
                    end
                end
                ST_SKIP: begin
                    edge_cnt <= 8'h00;
                end
                default: begin
                    state <= ST_IDLE;
                end
                endcase
            end
        end
    end

    // ========================================================
    // array write buffer; rate is set by the bus, not the array
    psr_wr_fifo #(
        .WIDTH (41),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_data),
        .out_valid_o (mem_wr_valid_o),
        .out_ready_i (mem_wr_ready_i),
        .out_data_o  (fifo_out)
    );

endmodule

/* bench/psr_host_model.sv */
// host bus master model: chip select, bus clock, data and strobe mask
// assumes pins move on the falling edge of the system clock clk_i
`timescale 1ns/1ps

module psr_host_model (
    // clock and device strobe drive
    input  wire       clk_i,
    input  wire       strobe_mask_o_i,
    input  wire       strobe_mask_oe_i,
    // bus pins
    output reg        cs_n_o = 1'b1,
    output reg        bus_clk_o = 1'b0,
    output reg  [7:0] dq_o = 8'h00,
    output wire       strobe_lvl_o
);
    reg h_oe = 1'b0;
    reg h_val = 1'b0;
    reg idle_t = 1'b0;

    // ====================
    // strobe wire: an undriven line toggles, so a stale level never matches
    always @(posedge clk_i) idle_t <= ~idle_t;
    assign strobe_lvl_o = strobe_mask_oe_i ? strobe_mask_o_i :
                          (h_oe ? h_val : idle_t);

    // one bus edge with data centred: two cycles either side of the edge
    task bus_edge(input [7:0] b, input m, input drv);
        begin
            dq_o = b;
            h_val = m;
            h_oe = drv;
            repeat (2) @(negedge clk_i);
            bus_clk_o = ~bus_clk_o;
            repeat (2) @(negedge clk_i);
        end
    endtask

    task xfer(input [47:0] ca, input integer lat, input integer n,
              input [15:0] d0, input [1:0] m0, input zl);
        integer    i;
        reg [15:0] w;
        begin
            cs_n_o = 1'b0;
            repeat (4) @(negedge clk_i);
            for (i = 0; i < 6; i = i + 1)
                bus_edge(ca[47-8*i -: 8], 1'b0, 1'b0);
            for (i = 0; i < lat; i = i + 1)
                bus_edge(~dq_o, 1'b0, 1'b1);
            for (i = 0; i < n; i = i + 1) begin
                w = d0 + {i[7:0], i[7:0]};
                bus_edge(w[15:8], i == 0 && m0[1], !zl);
                bus_edge(w[7:0], i == 0 && m0[0], !zl);
            end
            h_oe = 1'b0;
            cs_n_o = 1'b1;
            dq_o = ~dq_o;
            repeat (4) @(negedge clk_i);
        end
    endtask
endmodule

/* bench/psr_write_path_sva.sv */
// assertions on the write path ports, bound into the design
// assumes the design constants header is on the include path
`timescale 1ns/1ps
`include "psr_consts.vh"

module psr_write_path_sva (
    // clock and bus side
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        cs_n_i,
    input wire        bus_clk_i,
    input wire        strobe_mask_o,
    input wire        strobe_mask_oe_o,
    input wire        refresh_due_i,
    // array side and status
    input wire        mem_wr_valid_o,
    input wire        mem_wr_ready_i,
    input wire [22:0] mem_wr_addr_o,
    input wire [15:0] mem_wr_data_o,
    input wire        wr_fifo_ready_o,
    input wire        overflow_o,
    input wire        busy_o,
    input wire [15:0] primary_config_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ====================
    a_strobe_on_time: assert property (
        $fell(cs_n_i) && !bus_clk_i |-> ##3 strobe_mask_oe_o [*8])
        else $error("strobe not driven in command phase");
    a_strobe_level: assert property (
        $rose(strobe_mask_oe_o) |-> strobe_mask_o ==
        (primary_config_o[`PSR_FIXED_BIT] | refresh_due_i))
        else $error("latency indication wrong");
    a_strobe_release: assert property (
        $rose(strobe_mask_oe_o) |-> ##[1:40] !strobe_mask_oe_o)
        else $error("strobe held past command phase");
    a_word_hold: assert property (
        mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o &&
        $stable(mem_wr_addr_o) && $stable(mem_wr_data_o))
        else $error("array word changed before taken");
    a_full_valid: assert property (
        !wr_fifo_ready_o |-> mem_wr_valid_o)
        else $error("full buffer without a valid word");
    a_drop_full: assert property (
        $rose(overflow_o) |-> $past(wr_fifo_ready_o) == 1'b0)
        else $error("overflow without a full buffer");
    a_busy_idle: assert property (
        cs_n_i [*5] |-> !busy_o)
        else $error("busy while deselected");
    a_cfg_in_write: assert property (
        $changed(primary_config_o) |-> $past(busy_o))
        else $error("configuration changed outside a transaction");
endmodule

bind psr_write_path psr_write_path_sva u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .bus_clk_i(bus_clk_i), .strobe_mask_o(strobe_mask_o),
    .strobe_mask_oe_o(strobe_mask_oe_o), .refresh_due_i(refresh_due_i),
    .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
    .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o),
    .wr_fifo_ready_o(wr_fifo_ready_o), .overflow_o(overflow_o),
    .busy_o(busy_o), .primary_config_o(primary_config_o));

/* bench/tb_top.sv */
// top bench: host model on the pins, expected-word queue on the array port
// assumes design, host model and checker are compiled ahead of this file
`timescale 1ns/1ps
`include "psr_consts.vh"

module tb_top;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg         refresh_due_i = 1'b0;
    reg         mem_wr_ready_i = 1'b1;
    wire        cs_n, bus_clk, sm_lvl, sm_o, sm_oe, valid, fready, ovf, busy;
    wire [7:0]  dq;
    wire [22:0] addr;
    wire [15:0] data, id0, id1, cfg0, cfg1;
    wire [1:0]  be;
    reg  [40:0] exp_q[$];
    integer     fails = 0;
    integer     tests_run = 0;
    integer     i;
    localparam [23:0] LAT_TAB = {`PSR_LAT_CODE_5, `PSR_LAT_CLK_5,
        `PSR_LAT_CODE_6, `PSR_LAT_CLK_6, `PSR_LAT_CODE_4, `PSR_LAT_CLK_4};

    always #12.5 clk_i = ~clk_i;

    psr_host_model host (.clk_i(clk_i), .strobe_mask_o_i(sm_o),
        .strobe_mask_oe_i(sm_oe), .cs_n_o(cs_n), .bus_clk_o(bus_clk),
        .dq_o(dq), .strobe_lvl_o(sm_lvl));
    psr_write_path uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .bus_clk_i(bus_clk), .dq_i(dq), .strobe_mask_i(sm_lvl),
        .strobe_mask_o(sm_o), .strobe_mask_oe_o(sm_oe),
        .refresh_due_i(refresh_due_i), .mem_wr_valid_o(valid),
        .mem_wr_ready_i(mem_wr_ready_i), .mem_wr_addr_o(addr),
        .mem_wr_data_o(data), .mem_wr_be_o(be), .wr_fifo_ready_o(fready),
        .overflow_o(ovf), .busy_o(busy), .device_ident_word0_o(id0),
        .device_ident_word1_o(id1), .primary_config_o(cfg0),
        .secondary_config_o(cfg1));

    // ====================
    task chk(input [40:0] got, input [40:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
                fails = fails + 1;
            end
        end
    endtask

    task summarize;
        begin
            if (fails == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // md: 0 linear, 1 legacy wrap, 2 hybrid wrap of b words
    task mem_wr(input [22:0] a, input integer lat, input integer n,
                input [1:0] m0, input integer b, input integer md);
        integer    k;
        reg [22:0] base, e;
        reg [15:0] d0;
        begin
            d0 = a[15:0] ^ 16'hA5C3;
            base = a & ~(b - 1);
            for (k = 0; k < n; k = k + 1) begin
                e = a + k;
                if (md == 1 || (md == 2 && k < b))
                    e = base + (a - base + k) % b;
                else if (md == 2)
                    e = base + k;
                // with the array stalled only a full buffer survives
                if (k < 8 || mem_wr_ready_i)
                    exp_q.push_back({e, d0 + {k[7:0], k[7:0]},
                                     k == 0 ? ~m0 : 2'b11});
            end
            host.xfer({2'b00, md == 0, 9'h000, a[22:9], a[8:3], 13'h0000,
                       a[2:0]}, lat, n, d0, m0, 1'b0);
        end
    endtask

    task reg_wr(input [7:0] sel, input [7:0] idx, input [15:0] d);
        host.xfer({8'h60, 8'h00, sel, 16'h0000, idx}, 0, 1, d, 2'b00, 1'b1);
    endtask

    task drain;
        integer t;
        begin
            for (t = 0; t < 3000 && exp_q.size() > 0; t = t + 1)
                @(negedge clk_i);
            if (exp_q.size() > 0) begin
                $display("[FAIL] t=%0t left %h exp %h", $time,
                         exp_q.size(), 0);
                fails = fails + 1;
                summarize;
            end
        end
    endtask

    always @(posedge clk_i) begin
        if (valid === 1'b1 && mem_wr_ready_i) begin
            if (exp_q.size() == 0)
                chk({addr, data, be}, 41'bx);
            else
                chk({addr, data, be}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        chk({cfg0, cfg1}, {`PSR_PRIMARY_RST, `PSR_SECONDARY_RST});
        chk({id0, id1, valid, ovf, busy, sm_oe},
            {`PSR_IDENT0_VAL, `PSR_IDENT1_VAL, 4'h0});
        rst_n_i = 1'b1;
        @(negedge clk_i);
        reg_wr(`PSR_RSEL_CONFIG, `PSR_RIDX_PRIMARY, 16'h8FE7);
        chk(cfg0, 16'h8FE7);
        reg_wr(8'h00, 8'h00, 16'h1234);
        chk({cfg0, id0}, {16'h8FE7, `PSR_IDENT0_VAL});
        reg_wr(`PSR_RSEL_CONFIG, `PSR_RIDX_SECONDARY, 16'h0003);
        chk(cfg1, 16'h0003);
        reg_wr(`PSR_RSEL_CONFIG, 8'h02, 16'h0000);
        chk({cfg0, cfg1}, {16'h8FE7, 16'h0003});
        mem_wr(23'h1234A, 2 * `PSR_LAT_CLK_3, 3, 2'b10, 0, 0);
        drain;
        refresh_due_i = 1'b1;
        mem_wr(23'h7FFFFF, 4 * `PSR_LAT_CLK_3, 2, 2'b01, 0, 0);
        drain;
        refresh_due_i = 1'b0;
        host.xfer({8'hE0, 40'h0}, 6, 1, 16'hFFFF, 2'b00, 1'b0);
        reg_wr(`PSR_RSEL_CONFIG, `PSR_RIDX_PRIMARY, 16'h8FE6);
        mem_wr(23'h00106, 6, 4, 2'b00, `PSR_BLEN_WORDS_16B, 1);
        drain;
        reg_wr(`PSR_RSEL_CONFIG, `PSR_RIDX_PRIMARY, 16'h8FE2);
        mem_wr(23'h00206, 6, 10, 2'b00, `PSR_BLEN_WORDS_16B, 2);
        drain;
        mem_wr_ready_i = 1'b0;
        mem_wr(23'h00400, 6, 9, 2'b00, 0, 0);
        chk({ovf, fready, valid}, 3'b101);
        mem_wr_ready_i = 1'b1;
        drain;
        for (i = 0; i < 3; i = i + 1) begin
            reg_wr(`PSR_RSEL_CONFIG, `PSR_RIDX_PRIMARY,
                   {8'h8F, LAT_TAB[8*i+4 +: 4], 4'hF});
            mem_wr(23'h00500, 4 * LAT_TAB[8*i +: 4], 1, 2'b00, 0, 0);
            drain;
        end
        // a reserved latency code runs at the default count
        reg_wr(`PSR_RSEL_CONFIG, `PSR_RIDX_PRIMARY, 16'h8F2F);
        mem_wr(23'h00600, 4 * `PSR_LAT_CLK_6, 1, 2'b00, 0, 0);
        drain;
        chk(valid, 1'b0);
        summarize;
    end
endmodule
